// [cidrx_pkg.sv]
// Function
// - Request input low puts the receiver into full active mode.
// - Standby is entered only with request high and ring timing high.
// - Ring timing low powers the oscillator and ring qualification logic.
// - Ring energy enables the oscillator and ring qualification logic.
// - Ring-valid open-drain output pulls low while the ring stays qualified.
// - Range select high sets timing for the high-frequency crystal.
// - Range select low sets timing for the low-frequency resonator.
// - Carrier-present open-drain output pulls low while carrier stays valid.
// - Carrier dropouts shorter than 8 ms do not release carrier-present.
// - Raw data output follows the demodulator while carrier is present.
// - Raw data includes seizure pattern and the mark period.
// - Raw data output stays high without carrier.
// - Checked data follows the demodulator only after validation with carrier.
// - Checked data never shows the alternating seizure pattern.
// - Checked data stays high outside validated carrier condition.
// - Tone at 1200 Hz decodes as mark, 2200 Hz as space.
// - Line data is 1200 bit/s asynchronous serial characters.
// - Carrier-present asserts 14 ms after carrier appears.
// - Carrier-present releases no sooner than 8 ms after data ends.
// - Crystal oscillator becomes usable 2 ms after being enabled.
// - Request input may come from ring-valid, carrier-present or a controller.
// - Ring integrator counts up at 800 Hz above, down at 400 Hz below.
// - Ring qualifies at count 48 and disqualifies at count 32.
// - Request and ring timing both high, with ring energy low, return the device to standby.
package cidrx_pkg;

    // ==========================================================
    // Clock and tone timing
    localparam int CLK_HZ       = 100_000_000;
    localparam int CLK_KHZ      = CLK_HZ / 1000;
    localparam int MARK_HZ      = 1200;
    localparam int SPACE_HZ     = 2200;
    localparam int SPLIT_HZ     = 1700;
    localparam int TONE_LO_HZ   = 1000;
    localparam int TONE_HI_HZ   = 3000;
    localparam int BIT_RATE     = 1200;
    localparam int OVERSAMPLE   = 16;
    localparam int HALF_MARK    = CLK_HZ / (2 * MARK_HZ);
    localparam int HALF_SPACE   = CLK_HZ / (2 * SPACE_HZ);
    localparam int HALF_SPLIT   = CLK_HZ / (2 * SPLIT_HZ);
    localparam int HALF_MIN     = CLK_HZ / (2 * TONE_HI_HZ);
    localparam int HALF_MAX     = CLK_HZ / (2 * TONE_LO_HZ);
    localparam int SAMPLE_CYC   = CLK_HZ / (BIT_RATE * OVERSAMPLE);

    // ==========================================================
    // Times in ms and derived cycle counts
    localparam int ACQ_MS       = 14;
    localparam int HYST_MS      = 8;
    localparam int MARK_MS      = 50;
    localparam int XTAL_ST_MS   = 2;
    localparam int RES_ST_MS    = 2;
    localparam int ACQ_CYC      = ACQ_MS * CLK_KHZ;
    localparam int HYST_CYC     = HYST_MS * CLK_KHZ;
    localparam int MARK_CYC     = MARK_MS * CLK_KHZ;
    localparam int XTAL_ST_CYC  = XTAL_ST_MS * CLK_KHZ;
    localparam int RES_ST_CYC   = RES_ST_MS * CLK_KHZ;

    // ==========================================================
    // Ring integrator
    localparam int RING_UP_HZ   = 800;
    localparam int RING_DN_HZ   = 400;
    localparam int RING_UP_CYC  = (CLK_HZ + RING_UP_HZ - 1) / RING_UP_HZ;
    localparam int RING_DN_CYC  = (CLK_HZ + RING_DN_HZ - 1) / RING_DN_HZ;
    localparam logic [5:0] RING_QUAL = 6'h30;
    localparam logic [5:0] RING_DISQ = 6'h20;
    localparam logic [5:0] RING_TOP  = 6'h3f;

    // ==========================================================
    // Widths, buffer and pin vector layout
    localparam int TW           = 24;
    localparam int FIFO_W       = 2;
    localparam int FIFO_D       = 16;
    localparam logic [4:0] FIFO_PRIME = 5'h08;
    localparam int IN_N         = 7;
    localparam int IX_REQ       = 0;
    localparam int IX_RT        = 1;
    localparam int IX_ENERGY    = 2;
    localparam int IX_QUAL      = 3;
    localparam int IX_XSEL      = 4;
    localparam int IX_LINE      = 5;
    localparam int IX_OSC       = 6;
    localparam logic [IN_N-1:0] SYNC_RST = 7'h13;

    // ==========================================================
    // Power state
    typedef enum logic [2:0] {
        ST_STANDBY = 3'b001,
        ST_RING    = 3'b010,
        ST_ACTIVE  = 3'b100
    } cidrx_state_e;

endpackage : cidrx_pkg

// [cidrx_top.sv]
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// Sample buffer between the demodulator and the data pins
module cidrx_fifo #(
    parameter int W = 2,
    parameter int D = 16
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem [D];
    logic [AW:0]  wr_ptr;
    logic [AW:0]  rd_ptr;
    logic         full;
    logic         empty;

    // Extra pointer bit tells full from empty.
    assign empty     = (wr_ptr == rd_ptr);
    assign full      = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rd_ptr[AW-1:0]];

    // Write side.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wr_ptr <= '0;
        end else if (in_valid && in_ready) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
            wr_ptr              <= wr_ptr + 1'b1;
        end
    end

    // Read side.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rd_ptr <= '0;
        end else if (out_valid && out_ready) begin
            rd_ptr <= rd_ptr + 1'b1;
        end
    end

endmodule : cidrx_fifo

// ==========================================================
// Receiver control, demodulator and pin logic
module cidrx_top
    import cidrx_pkg::*;
#(
    parameter int P_SAMPLE_CYC  = SAMPLE_CYC,
    parameter int P_HALF_SPLIT  = HALF_SPLIT,
    parameter int P_HALF_MIN    = HALF_MIN,
    parameter int P_HALF_MAX    = HALF_MAX,
    parameter int P_ACQ_CYC     = ACQ_CYC,
    parameter int P_HYST_CYC    = HYST_CYC,
    parameter int P_MARK_CYC    = MARK_CYC,
    parameter int P_XTAL_ST_CYC = XTAL_ST_CYC,
    parameter int P_RES_ST_CYC  = RES_ST_CYC,
    parameter int P_RING_UP_CYC = RING_UP_CYC,
    parameter int P_RING_DN_CYC = RING_DN_CYC
) (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic active_request_n,
    input  wire logic ring_hold_timing_in,
    input  wire logic ring_energy_in,
    input  wire logic ring_qualify_in,
    input  wire logic xtal_range_select,
    input  wire logic line_tone_in,
    input  wire logic osc_drive_in,
    output logic      osc_drive_out,
    input  wire logic ring_valid_n_in,
    output logic      ring_valid_n_out,
    output logic      ring_valid_n_oe,
    input  wire logic carrier_present_n_in,
    output logic      carrier_present_n_out,
    output logic      carrier_present_n_oe,
    output logic      demod_raw_out,
    output logic      demod_checked_out
);

    // Timer limit test shared by the oscillator, ring rate, carrier, mark and sample counters.
    function automatic logic reached(input logic [TW-1:0] cnt, input int lim);
        reached = (cnt >= TW'(lim - 1));
    endfunction : reached

    // ==========================================================
    // Pin synchronisers
    logic [IN_N-1:0] pin_vec;
    logic [IN_N-1:0] s1;
    logic [IN_N-1:0] s2;
    logic [IN_N-1:0] s3;
    logic [IN_N-1:0] filt;

    assign pin_vec = {osc_drive_in, line_tone_in, xtal_range_select, ring_qualify_in,
                      ring_energy_in, ring_hold_timing_in, active_request_n};

    // Three stages per pin; a change is taken once stages two and three agree.
    for (genvar i = 0; i < IN_N; i++) begin : g_sync
        always_ff @(posedge clk) begin
            if (!nrst) begin
                s1[i]   <= SYNC_RST[i];
                s2[i]   <= SYNC_RST[i];
                s3[i]   <= SYNC_RST[i];
                filt[i] <= SYNC_RST[i];
            end else begin
                s1[i] <= pin_vec[i];
                s2[i] <= s1[i];
                s3[i] <= s2[i];
                if (s2[i] == s3[i]) begin
                    filt[i] <= s3[i];
                end
            end
        end
    end

    // ==========================================================
    // Power state
    cidrx_state_e state;
    cidrx_state_e next_state;
    logic         standby;

    // Request low wins; ring timing or line energy gives partial power.
    always_comb begin
        if (!filt[IX_REQ]) begin
            next_state = ST_ACTIVE;
        end else if (!filt[IX_RT] || filt[IX_ENERGY]) begin
            next_state = ST_RING;
        end else begin
            next_state = ST_STANDBY;
        end
    end

    // State register.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state <= ST_STANDBY;
        end else begin
            state <= next_state;
        end
    end

    assign standby = (state == ST_STANDBY);

    // ==========================================================
    // Oscillator enable and start-up
    logic [TW-1:0] osc_cnt;
    logic          osc_ready;

    // Start-up wait depends on the selected reference range.
    always_ff @(posedge clk) begin
        if (!nrst || standby) begin
            osc_cnt   <= '0;
            osc_ready <= 1'b0;
        end else if (!osc_ready) begin
            osc_cnt <= osc_cnt + 1'b1;
            if (filt[IX_XSEL] ? reached(osc_cnt, P_XTAL_ST_CYC)
                              : reached(osc_cnt, P_RES_ST_CYC)) begin
                osc_ready <= 1'b1;
            end
        end
    end

    // Inverting drive stage, idle low while the oscillator is off.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            osc_drive_out <= 1'b0;
        end else begin
            osc_drive_out <= !standby && !filt[IX_OSC];
        end
    end

    // ==========================================================
    // Ring integrator
    logic [TW-1:0] up_cnt;
    logic [TW-1:0] dn_cnt;
    logic          up_tick;
    logic          dn_tick;
    logic [5:0]    ring_cnt;
    logic          ring_valid;

    assign up_tick = reached(up_cnt, P_RING_UP_CYC);
    assign dn_tick = reached(dn_cnt, P_RING_DN_CYC);

    // Rate dividers for counting up and down.
    always_ff @(posedge clk) begin
        if (!nrst || standby) begin
            up_cnt <= '0;
            dn_cnt <= '0;
        end else begin
            up_cnt <= up_tick ? '0 : up_cnt + 1'b1;
            dn_cnt <= dn_tick ? '0 : dn_cnt + 1'b1;
        end
    end

    // Duty-cycle integrator, saturating at both ends.
    always_ff @(posedge clk) begin
        if (!nrst || standby) begin
            ring_cnt <= '0;
        end else if (filt[IX_QUAL] && up_tick && ring_cnt != RING_TOP) begin
            ring_cnt <= ring_cnt + 1'b1;
        end else if (!filt[IX_QUAL] && dn_tick && ring_cnt != 6'h00) begin
            ring_cnt <= ring_cnt - 1'b1;
        end
    end

    // Qualify at the upper count, drop at the lower one.
    always_ff @(posedge clk) begin
        if (!nrst || standby) begin
            ring_valid <= 1'b0;
        end else if (ring_cnt >= RING_QUAL) begin
            ring_valid <= 1'b1;
        end else if (ring_cnt <= RING_DISQ) begin
            ring_valid <= 1'b0;
        end
    end

    assign ring_valid_n_out = 1'b0;
    assign ring_valid_n_oe  = ring_valid;

    // ==========================================================
    // Tone demodulator
    logic          run;
    logic          line_prev;
    logic [TW-1:0] half_cnt;
    logic          tone_ok;
    logic          demod_bit;

    assign run = (state == ST_ACTIVE) && osc_ready;

    // Half-period of the squared line tone sets mark or space.
    always_ff @(posedge clk) begin
        if (!nrst || !run) begin
            line_prev <= 1'b0;
            half_cnt  <= '0;
            tone_ok   <= 1'b0;
            demod_bit <= 1'b1;
        end else begin
            line_prev <= filt[IX_LINE];
            if (filt[IX_LINE] != line_prev) begin
                half_cnt <= '0;
                tone_ok  <= (half_cnt >= TW'(P_HALF_MIN)) && (half_cnt <= TW'(P_HALF_MAX));
                if (half_cnt >= TW'(P_HALF_MIN) && half_cnt <= TW'(P_HALF_MAX)) begin
                    demod_bit <= (half_cnt > TW'(P_HALF_SPLIT));
                end
            end else if (half_cnt > TW'(P_HALF_MAX)) begin
                tone_ok <= 1'b0;
            end else begin
                half_cnt <= half_cnt + 1'b1;
            end
        end
    end

    // ==========================================================
    // Carrier detect with acquisition and hold-over
    logic [TW-1:0] car_cnt;
    logic          carrier;

    // Counts tone time while absent, dropout time while present.
    always_ff @(posedge clk) begin
        if (!nrst || !run) begin
            car_cnt <= '0;
            carrier <= 1'b0;
        end else if (!carrier) begin
            if (!tone_ok) begin
                car_cnt <= '0;
            end else if (reached(car_cnt, P_ACQ_CYC)) begin
                car_cnt <= '0;
                carrier <= 1'b1;
            end else begin
                car_cnt <= car_cnt + 1'b1;
            end
        end else begin
            if (tone_ok) begin
                car_cnt <= '0;
            end else if (reached(car_cnt, P_HYST_CYC)) begin
                car_cnt <= '0;
                carrier <= 1'b0;
            end else begin
                car_cnt <= car_cnt + 1'b1;
            end
        end
    end

    assign carrier_present_n_out = 1'b0;
    assign carrier_present_n_oe  = carrier;

    // ==========================================================
    // Validation: a long unbroken mark follows the seizure pattern
    logic [TW-1:0] mark_cnt;
    logic          validated;

    // Alternating bits keep restarting the count, so they never pass.
    always_ff @(posedge clk) begin
        if (!nrst || !carrier) begin
            mark_cnt  <= '0;
            validated <= 1'b0;
        end else if (!validated) begin
            if (!demod_bit) begin
                mark_cnt <= '0;
            end else if (reached(mark_cnt, P_MARK_CYC)) begin
                validated <= 1'b1;
            end else begin
                mark_cnt <= mark_cnt + 1'b1;
            end
        end
    end

    // ==========================================================
    // Sample buffer and data pins
    logic [TW-1:0] samp_cnt;
    logic          samp_tick;
    logic [4:0]    prime_cnt;
    logic          primed;
    logic [1:0]    push_data;
    logic [1:0]    pop_data;
    logic          push_ready;
    logic          pop_valid;

    assign samp_tick = reached(samp_cnt, P_SAMPLE_CYC);
    assign primed    = (prime_cnt == FIFO_PRIME);
    assign push_data = {carrier ? demod_bit : 1'b1,
                        (carrier && validated) ? demod_bit : 1'b1};

    // Sample clock and start-up fill before draining begins.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            samp_cnt  <= '0;
            prime_cnt <= '0;
        end else begin
            samp_cnt <= samp_tick ? '0 : samp_cnt + 1'b1;
            if (samp_tick && !primed && push_ready) begin
                prime_cnt <= prime_cnt + 1'b1;
            end
        end
    end

    cidrx_fifo #(
        .W (FIFO_W),
        .D (FIFO_D)
    ) u_fifo (
        .clk       (clk),
        .nrst      (nrst),
        .in_valid  (samp_tick),
        .in_ready  (push_ready),
        .in_data   (push_data),
        .out_valid (pop_valid),
        .out_ready (samp_tick && primed),
        .out_data  (pop_data)
    );

    // Data pins update from the buffer and idle high.
    always_ff @(posedge clk) begin
        if (!nrst || standby) begin
            demod_raw_out     <= 1'b1;
            demod_checked_out <= 1'b1;
        end else if (samp_tick && primed && pop_valid) begin
            demod_raw_out     <= pop_data[1];
            demod_checked_out <= pop_data[0];
        end
    end

    // ==========================================================
    // Checks
    localparam int OUT_LAT = (FIFO_PRIME + 3) * P_SAMPLE_CYC;
    logic [TW-1:0] nocar_cnt;

    // Cycles since the carrier flag last dropped.
    always_ff @(posedge clk) begin
        if (!nrst || carrier) begin
            nocar_cnt <= '0;
        end else if (nocar_cnt != {TW{1'b1}}) begin
            nocar_cnt <= nocar_cnt + 1'b1;
        end
    end

    sequence seq_request;
        !filt[IX_REQ];
    endsequence

    sequence seq_active;
        state == ST_ACTIVE;
    endsequence

    AST_ACTIVE_ON_REQUEST: assert property (@(posedge clk) disable iff (!nrst)
        seq_request |=> seq_active)
        else $error("request low did not give active mode");

    AST_STANDBY_ENTRY: assert property (@(posedge clk) disable iff (!nrst)
        $rose(standby) |-> $past(filt[IX_REQ]) && $past(filt[IX_RT]))
        else $error("standby entered without request and timing high");

    AST_STANDBY_QUIET: assert property (@(posedge clk) disable iff (!nrst)
        standby ##1 standby |-> !ring_valid_n_oe && !carrier_present_n_oe
                               && demod_raw_out && demod_checked_out)
        else $error("outputs not idle in standby");

    AST_RING_QUALIFY: assert property (@(posedge clk) disable iff (!nrst)
        !standby && !ring_valid && ring_cnt >= RING_QUAL ##1 !standby |-> ring_valid)
        else $error("ring not qualified at count 48");

    AST_RING_HELD: assert property (@(posedge clk) disable iff (!nrst)
        $fell(ring_valid_n_oe) && !standby |-> $past(ring_cnt) <= RING_DISQ)
        else $error("ring valid dropped above count 32");

    AST_RING_STEP: assert property (@(posedge clk) disable iff (!nrst)
        !standby && !up_tick && !dn_tick ##1 !standby |-> $stable(ring_cnt))
        else $error("integrator moved without a rate tick");

    AST_CARRIER_ACQ: assert property (@(posedge clk) disable iff (!nrst)
        $rose(carrier) |-> $past(car_cnt) == TW'(P_ACQ_CYC - 1))
        else $error("carrier asserted before acquisition time");

    AST_CARRIER_HOLD: assert property (@(posedge clk) disable iff (!nrst)
        $fell(carrier) && $past(run) && run |-> $past(car_cnt) == TW'(P_HYST_CYC - 1))
        else $error("carrier released before hold-over time");

    AST_RAW_IDLE: assert property (@(posedge clk) disable iff (!nrst)
        !carrier && nocar_cnt > TW'(OUT_LAT) |-> demod_raw_out && demod_checked_out)
        else $error("data output low long after carrier loss");

    AST_VALID_NEEDS_MARK: assert property (@(posedge clk) disable iff (!nrst)
        $rose(validated) |-> $past(mark_cnt) == TW'(P_MARK_CYC - 1) && $past(demod_bit))
        else $error("validation passed without the full mark run");

    AST_OSC_START: assert property (@(posedge clk) disable iff (!nrst)
        $rose(osc_ready) && filt[IX_XSEL] |-> $past(osc_cnt) == TW'(P_XTAL_ST_CYC - 1))
        else $error("oscillator ready at wrong time");

endmodule : cidrx_top

`default_nettype wire

// [cidrx_line_model.sv]
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// Line model: squared tone from the central office side
module cidrx_line_model (
    input  wire logic clk,
    input  wire logic tone_on,
    input  wire logic bit_val,
    output logic      line
);
    logic [7:0] cnt = 8'h00;
    logic       prev = 1'b0;
    logic       lvl  = 1'b0;

    assign line = lvl;

    // Toggle each half period; a change of tone_on restarts the count at once.
    // Without a tone the line still moves, but far too slowly to look like one.
    always @(posedge clk) begin
        prev <= tone_on;
        if (cnt == 8'h00 || prev != tone_on) begin
            lvl  <= ~lvl;
            cnt  <= !tone_on ? 8'hc7 : (bit_val ? 8'h27 : 8'h13);
        end else begin
            cnt <= cnt - 8'h01;
        end
    end
endmodule : cidrx_line_model

`default_nettype wire

// [cidrx_top_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// Testbench of the receiver control block
module cidrx_top_tb_top;
    logic clk, nrst, req_n, rt, energy, qual, xsel, osc_in, tone_on, bit_val;
    int   n_raw_lo = 0, n_chk_lo = 0, n_cp_off = 0, n_osc_hi = 0;
    int   b_raw_lo, b_chk_lo, b_cp_off;
    wire  line, osc_out, rv_out, rv_oe, cp_out, cp_oe, raw, chk_o;
    wire  rv_pin = rv_oe ? 1'b0 : 1'b1;
    wire  cp_pin = cp_oe ? 1'b0 : 1'b1;
    int   error_cnt = 0;
    int   compares = 0;
    int   cycles = 0;

    // Shortened timing so that a whole call fits in a short run.
    localparam int T_SAMPLE = 16;
    localparam int T_SPLIT  = 30;
    localparam int T_MIN    = 16;
    localparam int T_MAX    = 50;
    localparam int T_ACQ    = 200;
    localparam int T_HYST   = 100;
    localparam int T_MARK   = 300;
    localparam int T_XTAL   = 50;
    localparam int T_RES    = 90;
    localparam int T_UP     = 4;
    localparam int T_DN     = 8;

    // Cycles that stand for a time in ms, scaled from the acquisition time.
    function automatic int ms_cyc(input int ms);
        return ms * T_ACQ / 14;
    endfunction : ms_cyc

    cidrx_top #(.P_SAMPLE_CYC(T_SAMPLE), .P_HALF_SPLIT(T_SPLIT), .P_HALF_MIN(T_MIN),
        .P_HALF_MAX(T_MAX), .P_ACQ_CYC(T_ACQ), .P_HYST_CYC(T_HYST), .P_MARK_CYC(T_MARK),
        .P_XTAL_ST_CYC(T_XTAL), .P_RES_ST_CYC(T_RES), .P_RING_UP_CYC(T_UP),
        .P_RING_DN_CYC(T_DN)) DUT (
        .clk(clk), .nrst(nrst), .active_request_n(req_n), .ring_hold_timing_in(rt),
        .ring_energy_in(energy), .ring_qualify_in(qual), .xtal_range_select(xsel),
        .line_tone_in(line), .osc_drive_in(osc_in), .osc_drive_out(osc_out),
        .ring_valid_n_in(rv_pin), .ring_valid_n_out(rv_out), .ring_valid_n_oe(rv_oe),
        .carrier_present_n_in(cp_pin), .carrier_present_n_out(cp_out),
        .carrier_present_n_oe(cp_oe), .demod_raw_out(raw), .demod_checked_out(chk_o));

    cidrx_line_model LINE (.clk(clk), .tone_on(tone_on), .bit_val(bit_val), .line(line));

    // Clock of 100 MHz.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Random oscillator pin, output watchers and the hang limit.
    always @(posedge clk) begin
        osc_in <= 1'($urandom());
        if (raw === 1'b0) n_raw_lo <= n_raw_lo + 1;
        if (chk_o === 1'b0) n_chk_lo <= n_chk_lo + 1;
        if (cp_oe !== 1'b1) n_cp_off <= n_cp_off + 1;
        if (osc_out === 1'b1) n_osc_hi <= n_osc_hi + 1;
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            test_done();
        end
    end

    task automatic chk(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    // Waits, with a bound, for the ring or carrier enable to reach a level.
    task automatic wait_oe(input bit ring, input logic v, input int lim);
        for (int n = 0; n < lim && (ring ? rv_oe : cp_oe) !== v; n++) @(posedge clk);
    endtask : wait_oe

    task automatic send(input logic b, input int n);
        bit_val <= b;
        cyc(n);
    endtask : send

    task automatic clear;
        b_raw_lo = n_raw_lo;
        b_chk_lo = n_chk_lo;
        b_cp_off = n_cp_off;
    endtask : clear

    task automatic test_done;
        $display("compares=%0d error_cnt=%0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done

    // Main sequence: ring check, active receive, carrier loss, back to standby.
    initial begin
        {nrst, energy, qual, xsel, tone_on} = 5'h00;
        {req_n, rt, bit_val} = 3'h7;
        clear();
        void'($urandom(32'hf515d8b2));
        cyc(16);
        nrst <= 1'b1;
        xsel <= 1'($urandom());
        cyc(8);
        chk(rv_oe, 1'b0);
        chk(raw, 1'b1);
        chk(n_osc_hi != 0, 1'b0);
        energy <= 1'b1;
        cyc(20);
        chk(n_osc_hi != 0, 1'b1);
        rt   <= 1'b0;
        qual <= 1'b1;
        cyc(150);
        chk(rv_oe, 1'b0);
        wait_oe(1'b1, 1'b1, 300);
        chk(rv_oe, 1'b1);
        chk(rv_out, 1'b0);
        qual <= 1'b0;
        cyc(80);
        chk(rv_oe, 1'b1);
        wait_oe(1'b1, 1'b0, 300);
        chk(rv_oe, 1'b0);
        {energy, rt, req_n} <= 3'b010;
        cyc(ms_cyc(15) + 1);
        tone_on <= 1'b1;
        send(1'b0, 150);
        chk(cp_oe, 1'b0);
        wait_oe(1'b0, 1'b1, 300);
        chk(cp_oe, 1'b1);
        chk(cp_out, 1'b0);
        clear();
        for (int i = 0; i < 8; i++) send(i[0], 256);
        chk(n_raw_lo != b_raw_lo, 1'b1);
        chk(n_chk_lo != b_chk_lo, 1'b0);
        send(1'b1, 600);
        clear();
        send(1'b0, 256);
        for (int i = 0; i < 15; i++) send(1'($urandom()), 256);
        chk(n_raw_lo != b_raw_lo, 1'b1);
        chk(n_chk_lo != b_chk_lo, 1'b1);
        tone_on <= 1'b0;
        cyc(40);
        tone_on <= 1'b1;
        cyc(100);
        chk(n_cp_off != b_cp_off, 1'b0);
        tone_on <= 1'b0;
        cyc(60);
        chk(cp_oe, 1'b1);
        wait_oe(1'b0, 1'b0, 400);
        chk(cp_oe, 1'b0);
        cyc(200);
        chk(raw, 1'b1);
        chk(chk_o, 1'b1);
        req_n <= 1'b1;
        cyc(10);
        chk(osc_out, 1'b0);
        chk(cp_oe, 1'b0);
        test_done();
    end
endmodule : cidrx_top_tb_top

`default_nettype wire
